// *** vgs_pkg.sv ***
// vgs_pkg: constants and carrier types for the general/sequencer register bank
// assumes one 25 MHz system clock; i/o ports are 16-bit byte-wide addresses
package vgs_pkg;

  localparam logic [15:0] VGS_PORT_MISC_WR  = 16'h03C2;
  localparam logic [15:0] VGS_PORT_INPUT_STATUS_ZERO_RD  = 16'h03C2;
  localparam logic [15:0] VGS_PORT_MISC_RD  = 16'h03CC;
  localparam logic [15:0] VGS_PORT_GUARD    = 16'h03C3;
  localparam logic [15:0] VGS_PORT_SEQ_IDX  = 16'h03C4;
  localparam logic [15:0] VGS_PORT_SEQ_DATA = 16'h03C5;
  localparam logic [15:0] VGS_PORT_FCR_RD   = 16'h03CA;
  localparam logic [15:0] VGS_BASE_MONO     = 16'h03B0;
  localparam logic [15:0] VGS_BASE_COLOR    = 16'h03D0;
  localparam logic [3:0]  VGS_OFS_STATUS1   = 4'hA;

  localparam logic [3:0] VGS_IDX_RESET = 4'h0;
  localparam logic [3:0] VGS_IDX_CLOCK = 4'h1;
  localparam logic [3:0] VGS_IDX_PLANE = 4'h2;
  localparam logic [3:0] VGS_IDX_FONT  = 4'h3;
  localparam logic [3:0] VGS_IDX_GUARD = 4'hF;

  // register field positions
  localparam int VGS_MISC_BASE_SEL = 0;
  localparam int VGS_MISC_VRAM     = 1;
  localparam int VGS_MISC_CLK_LO   = 2;
  localparam int VGS_MISC_PAGE     = 5;
  localparam int VGS_MISC_HSP      = 6;
  localparam int VGS_MISC_VSP      = 7;
  localparam int VGS_FCR_VSC       = 3;
  localparam int VGS_RST_ASYNC     = 0;
  localparam int VGS_RST_SYNC      = 1;
  localparam int VGS_CLK_CHAR8     = 0;
  localparam int VGS_CLK_HALF_LD   = 2;
  localparam int VGS_CLK_DOT_HALF  = 3;
  localparam int VGS_CLK_QUAD_LD   = 4;
  localparam int VGS_CLK_SCR_OFF   = 5;
  localparam int VGS_FONT_SEL      = 3;

  // writable-bit masks, reserved bits stay zero
  localparam logic [7:0] VGS_MASK_MISC  = 8'hEF;
  localparam logic [7:0] VGS_MASK_FCR   = 8'h08;
  localparam logic [7:0] VGS_MASK_IDX   = 8'h0F;
  localparam logic [7:0] VGS_MASK_RESET = 8'h03;
  localparam logic [7:0] VGS_MASK_CLOCK = 8'h3D;
  localparam logic [7:0] VGS_MASK_PLANE = 8'h0F;
  localparam logic [7:0] VGS_MASK_FONT  = 8'h3F;
  localparam logic [7:0] VGS_MASK_GUARD = 8'hE0;

  localparam logic [7:0] VGS_RST_VAL    = 8'h00;
  localparam logic [2:0] VGS_GUARD_OPEN = 3'h2;
  localparam logic [2:0] VGS_GUARD_SHUT = 3'h5;

  localparam logic [3:0] VGS_DOTS_NINE  = 4'h8;
  localparam logic [3:0] VGS_DOTS_EIGHT = 4'h7;

  typedef enum logic [1:0] {
    VGS_PCLK_25M175,
    VGS_PCLK_28M322,
    VGS_PCLK_EXT
  } vgs_pclk_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic [7:0]  wdata;
  } vgs_io_req_t;

  typedef struct packed {
    logic vsync_raw;
    logic hsync_raw;
    logic vretrace;
    logic hretrace;
    logic vdisp_en;
  } vgs_timing_t;

endpackage

// *** vgs_font_slot.sv ***
// vgs_font_slot: turns the scattered font map bits into a slot number
// assumes the caller registers the result
`timescale 1ns/10ps
module vgs_font_slot
  import vgs_pkg::*;
(
  input  wire logic [7:0] font_map_i,
  output logic      [2:0] slot_o
);

  logic [2:0] font_slot_a;
  logic [2:0] font_slot_b;

  // lowest-weight bit sits highest in the register
  assign font_slot_a = {font_map_i[3], font_map_i[2], font_map_i[5]};
  assign font_slot_b = {font_map_i[1], font_map_i[0], font_map_i[4]};
  assign slot_o      = font_map_i[VGS_FONT_SEL] ? font_slot_b : font_slot_a;

endmodule // vgs_font_slot

// *** vgs_char_clk.sv ***
// vgs_char_clk: dot, character and serializer-load enables
// assumes one enable per system clock stands for one selected pixel clock
`timescale 1ns/10ps
module vgs_char_clk
  import vgs_pkg::*;
(
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  input  wire logic sync_halt_i,
  input  wire logic async_halt_i,
  input  wire logic dot_halving_i,
  input  wire logic char_width_select_i,
  input  wire logic half_load_select_i,
  input  wire logic quad_load_select_i,
  output logic      dot_en_o,
  output logic      char_en_o,
  output logic      load_en_o
);

  logic       half_reg;
  logic [3:0] dot_cnt_reg;
  logic [1:0] load_cnt_reg;
  logic [3:0] last_dot;
  logic       dot_tick;
  logic       halted;

  assign last_dot = char_width_select_i ? VGS_DOTS_EIGHT : VGS_DOTS_NINE;
  // sync halt waits for the character boundary, async halt does not wait
  assign halted   = async_halt_i || (sync_halt_i && dot_cnt_reg == 4'h0);
  assign dot_tick = !halted && (!dot_halving_i || half_reg);

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      half_reg <= 1'b0;
    else if (halted)
      half_reg <= 1'b0;
    else
      half_reg <= ~half_reg;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      dot_cnt_reg <= 4'h0;
    else if (async_halt_i)
      dot_cnt_reg <= 4'h0;
    else if (dot_tick)
      dot_cnt_reg <= (dot_cnt_reg == last_dot) ? 4'h0 : dot_cnt_reg + 4'h1;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      load_cnt_reg <= 2'h0;
    else if (async_halt_i)
      load_cnt_reg <= 2'h0;
    else if (dot_tick && dot_cnt_reg == last_dot)
      load_cnt_reg <= load_cnt_reg + 2'h1;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      dot_en_o  <= 1'b0;
      char_en_o <= 1'b0;
      load_en_o <= 1'b0;
    end
    else
    begin
      dot_en_o  <= dot_tick;
      char_en_o <= dot_tick && dot_cnt_reg == last_dot;
      if (quad_load_select_i)
        load_en_o <= dot_tick && dot_cnt_reg == last_dot && load_cnt_reg == 2'h3;
      else if (half_load_select_i)
        load_en_o <= dot_tick && dot_cnt_reg == last_dot && load_cnt_reg[0];
      else
        load_en_o <= dot_tick && dot_cnt_reg == last_dot;
    end
  end

endmodule // vgs_char_clk

// *** vgs_regs.sv ***
// vgs_regs: general output, feature control, input status and sequencer registers
// assumes i/o requests are single-cycle strobes synchronous to clk_sys_i
// How it works
// - general output written at 3C2h, read back at 3CCh
// - status one and feature write ports sit at 3BAh when base select is 0, 3DAh when 1
// - bit 7 inverts vertical sync, bit 6 inverts horizontal sync
// - bit 5 picks the lower or upper 64K memory page
// - clock field picks 25.175MHz, 28.322MHz or the external clock
// - processor video memory access allowed only while bit 1 is set
// - status zero bit 7 shows a pending vertical retrace interrupt
// - status zero bit 4 shows colour (1) or monochrome (0) monitor
// - status one bit 3 is high during vertical retrace
// - status one bit 0 is high during any retrace
// - status one bits 5:4 return a selected pair of pixel outputs
// - feature control written at base port, read at 3CAh; bit 3 ORs display enable
// - index at 3C4h bits 3:0 steers data accesses at 3C5h
// - reset bits low halt the sequencer synchronously or asynchronously
// - screen-off bit blanks video while syncs keep running
// - serializer loads every fourth, every other, or every character
// - dot halving bit divides the dot clock by two
// - character clock is nine dots, or eight when bit 0 is set
// - plane write enable bits gate processor writes per plane
// - font map A bits 5,3,2 choose the 8K slot when bit 3 is 0
// - font map B bits 4,1,0 choose the slot when bit 3 is 1
// - guard field 010 unlocks, 101 locks, other values keep state
// - extended register writes ignored while locked; host unlocks first
`timescale 1ns/10ps
module vgs_regs
  import vgs_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire vgs_io_req_t io_req_i,
  output logic      [7:0]  io_rdata_o,
  output logic             io_rvalid_o,
  input  wire vgs_timing_t timing_i,
  input  wire logic        retrace_irq_pending_i,
  input  wire logic        monitor_color_detect_i,
  input  wire logic [7:0]  pixel_outputs_i,
  input  wire logic [1:0]  plane_pair_sel_i,
  input  wire logic        cpu_mem_req_i,
  input  wire logic [3:0]  cpu_plane_wr_i,
  input  wire logic        ext_wr_req_i,
  output logic             vsync_o,
  output logic             hsync_o,
  output logic             blank_o,
  output logic             page_select_hi_o,
  output vgs_pclk_t        pclk_sel_o,
  output logic             cpu_mem_grant_o,
  output logic      [3:0]  plane_wr_o,
  output logic      [2:0]  font_slot_o,
  output logic             ext_unlocked_o,
  output logic             ext_wr_en_o,
  output logic             seq_running_o,
  output logic             dot_en_o,
  output logic             char_en_o,
  output logic             load_en_o
);

  logic [7:0]  general_output_reg;
  logic [7:0]  feature_ctrl_reg;
  logic [7:0]  sequencer_index;
  logic [7:0]  sequencer_reset_ctrl;
  logic [7:0]  sequencer_clocking_ctrl;
  logic [7:0]  plane_write_enable;
  logic [7:0]  font_map_select;
  logic [7:0]  extended_write_guard;
  logic        unlocked_reg;
  logic [15:0] idx_base;
  logic        hit_status1;
  logic        wr_seq_data;
  logic        wr_guard;
  logic [2:0]  ext_unlock_field;
  logic [7:0]  input_status_zero;
  logic [7:0]  input_status_one;
  logic [7:0]  rdata_next;
  logic        vsync_mix;
  logic [2:0]  font_slot;
  logic        sync_halt;
  logic        async_halt;

  assign idx_base    = general_output_reg[VGS_MISC_BASE_SEL] ? VGS_BASE_COLOR
                                                             : VGS_BASE_MONO;
  assign hit_status1 = io_req_i.addr == (idx_base | {12'h000, VGS_OFS_STATUS1});
  assign wr_seq_data = io_req_i.wr && io_req_i.addr == VGS_PORT_SEQ_DATA;
  assign wr_guard    = io_req_i.wr && (io_req_i.addr == VGS_PORT_GUARD ||
                       (wr_seq_data && sequencer_index[3:0] == VGS_IDX_GUARD));
  assign ext_unlock_field = io_req_i.wdata[7:5];

  // ---------------- general output / feature control
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      general_output_reg <= VGS_RST_VAL;
    else if (io_req_i.wr && io_req_i.addr == VGS_PORT_MISC_WR)
      general_output_reg <= io_req_i.wdata & VGS_MASK_MISC;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      feature_ctrl_reg <= VGS_RST_VAL;
    else if (io_req_i.wr && hit_status1)
      feature_ctrl_reg <= io_req_i.wdata & VGS_MASK_FCR;
  end

  // ---------------- sequencer index and data
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sequencer_index <= VGS_RST_VAL;
    else if (io_req_i.wr && io_req_i.addr == VGS_PORT_SEQ_IDX)
      sequencer_index <= io_req_i.wdata & VGS_MASK_IDX;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sequencer_reset_ctrl    <= VGS_RST_VAL;
      sequencer_clocking_ctrl <= VGS_RST_VAL;
      plane_write_enable      <= VGS_RST_VAL;
      font_map_select         <= VGS_RST_VAL;
    end
    else if (wr_seq_data)
    begin
      case (sequencer_index[3:0])
        VGS_IDX_RESET: sequencer_reset_ctrl    <= io_req_i.wdata & VGS_MASK_RESET;
        VGS_IDX_CLOCK: sequencer_clocking_ctrl <= io_req_i.wdata & VGS_MASK_CLOCK;
        VGS_IDX_PLANE: plane_write_enable      <= io_req_i.wdata & VGS_MASK_PLANE;
        VGS_IDX_FONT:  font_map_select         <= io_req_i.wdata & VGS_MASK_FONT;
        default:       ;
      endcase
    end
  end

  // ---------------- extended register guard
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      extended_write_guard <= VGS_RST_VAL;
    else if (wr_guard)
      extended_write_guard <= io_req_i.wdata & VGS_MASK_GUARD;
  end

  // locked from power-on; only the two codes change state
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      unlocked_reg <= 1'b0;
    else if (wr_guard && ext_unlock_field == VGS_GUARD_OPEN)
      unlocked_reg <= 1'b1;
    else if (wr_guard && ext_unlock_field == VGS_GUARD_SHUT)
      unlocked_reg <= 1'b0;
  end

  // ---------------- read path
  assign input_status_zero = {retrace_irq_pending_i, 2'b00,
                              monitor_color_detect_i, 4'h0};
  assign input_status_one  = {2'b00,
                              pixel_outputs_i[{plane_pair_sel_i, 1'b1}],
                              pixel_outputs_i[{plane_pair_sel_i, 1'b0}],
                              timing_i.vretrace, 2'b00,
                              timing_i.vretrace || timing_i.hretrace};

  always_comb
  begin
    rdata_next = 8'h00;
    if (io_req_i.addr == VGS_PORT_MISC_RD)
      rdata_next = general_output_reg;
    else if (io_req_i.addr == VGS_PORT_INPUT_STATUS_ZERO_RD)
      rdata_next = input_status_zero;
    else if (io_req_i.addr == VGS_PORT_FCR_RD)
      rdata_next = feature_ctrl_reg;
    else if (hit_status1)
      rdata_next = input_status_one;
    else if (io_req_i.addr == VGS_PORT_GUARD)
      rdata_next = extended_write_guard;
    else if (io_req_i.addr == VGS_PORT_SEQ_IDX)
      rdata_next = sequencer_index;
    else if (io_req_i.addr == VGS_PORT_SEQ_DATA)
    begin
      case (sequencer_index[3:0])
        VGS_IDX_RESET: rdata_next = sequencer_reset_ctrl;
        VGS_IDX_CLOCK: rdata_next = sequencer_clocking_ctrl;
        VGS_IDX_PLANE: rdata_next = plane_write_enable;
        VGS_IDX_FONT:  rdata_next = font_map_select;
        VGS_IDX_GUARD: rdata_next = extended_write_guard;
        default:       rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      io_rdata_o  <= 8'h00;
      io_rvalid_o <= 1'b0;
    end
    else
    begin
      io_rvalid_o <= io_req_i.rd;
      io_rdata_o  <= io_req_i.rd ? rdata_next : 8'h00;
    end
  end

  // ---------------- sync, blank and memory gating
  assign vsync_mix = feature_ctrl_reg[VGS_FCR_VSC] ? (timing_i.vsync_raw || timing_i.vdisp_en)
                                                   : timing_i.vsync_raw;

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      vsync_o <= 1'b0;
      hsync_o <= 1'b0;
      blank_o <= 1'b1;
    end
    else
    begin
      vsync_o <= vsync_mix ^ general_output_reg[VGS_MISC_VSP];
      hsync_o <= timing_i.hsync_raw ^ general_output_reg[VGS_MISC_HSP];
      // syncs above ignore screen-off on purpose
      blank_o <= sequencer_clocking_ctrl[VGS_CLK_SCR_OFF] ||
                 timing_i.vretrace || timing_i.hretrace;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      page_select_hi_o <= 1'b0;
      pclk_sel_o       <= VGS_PCLK_25M175;
      cpu_mem_grant_o  <= 1'b0;
      plane_wr_o       <= 4'h0;
    end
    else
    begin
      page_select_hi_o <= general_output_reg[VGS_MISC_PAGE];
      case (general_output_reg[VGS_MISC_CLK_LO +: 2])
        2'h0:    pclk_sel_o <= VGS_PCLK_25M175;
        2'h1:    pclk_sel_o <= VGS_PCLK_28M322;
        default: pclk_sel_o <= VGS_PCLK_EXT;
      endcase
      cpu_mem_grant_o <= cpu_mem_req_i && general_output_reg[VGS_MISC_VRAM];
      plane_wr_o      <= general_output_reg[VGS_MISC_VRAM] ?
                         (cpu_plane_wr_i & plane_write_enable[3:0]) : 4'h0;
    end
  end

  // ---------------- extended write gate and sequencer state
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ext_unlocked_o <= 1'b0;
      ext_wr_en_o    <= 1'b0;
      font_slot_o    <= 3'h0;
      seq_running_o  <= 1'b0;
    end
    else
    begin
      ext_unlocked_o <= unlocked_reg;
      ext_wr_en_o    <= ext_wr_req_i && unlocked_reg;
      font_slot_o    <= font_slot;
      seq_running_o  <= !sync_halt && !async_halt;
    end
  end

  assign sync_halt  = !sequencer_reset_ctrl[VGS_RST_SYNC];
  assign async_halt = !sequencer_reset_ctrl[VGS_RST_ASYNC];

  vgs_font_slot u_font_slot
  (
    .font_map_i (font_map_select),
    .slot_o     (font_slot)
  );

  vgs_char_clk u_char_clk
  (
    .clk_sys_i           (clk_sys_i),
    .rst_n_i             (rst_n_i),
    .sync_halt_i         (sync_halt),
    .async_halt_i        (async_halt),
    .dot_halving_i       (sequencer_clocking_ctrl[VGS_CLK_DOT_HALF]),
    .char_width_select_i (sequencer_clocking_ctrl[VGS_CLK_CHAR8]),
    .half_load_select_i  (sequencer_clocking_ctrl[VGS_CLK_HALF_LD]),
    .quad_load_select_i  (sequencer_clocking_ctrl[VGS_CLK_QUAD_LD]),
    .dot_en_o            (dot_en_o),
    .char_en_o           (char_en_o),
    .load_en_o           (load_en_o)
  );

  // ---------------- checks
  a_misc_readback: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    io_req_i.wr && io_req_i.addr == VGS_PORT_MISC_WR ##1
    !(io_req_i.wr && io_req_i.addr == VGS_PORT_MISC_WR) ##1
    io_req_i.rd && io_req_i.addr == VGS_PORT_MISC_RD && !io_req_i.wr
    |=> io_rvalid_o && io_rdata_o == ($past(io_req_i.wdata, 3) & VGS_MASK_MISC))
    else $error("general output readback mismatch");

  a_guard_unlock: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_guard && ext_unlock_field == VGS_GUARD_OPEN |=> ##1 ext_unlocked_o)
    else $error("guard did not unlock");

  a_locked_no_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !unlocked_reg |=> !ext_wr_en_o)
    else $error("extended write passed while locked");

  a_guard_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    wr_guard && ext_unlock_field != VGS_GUARD_OPEN && ext_unlock_field != VGS_GUARD_SHUT
    |=> $stable(unlocked_reg))
    else $error("guard changed on neutral code");

  a_vram_gate: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    cpu_mem_grant_o |-> $past(general_output_reg[VGS_MISC_VRAM]) && $past(cpu_mem_req_i))
    else $error("video memory granted while disabled");

  a_plane_gate: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (plane_wr_o & ~$past(plane_write_enable[3:0])) == 4'h0)
    else $error("write to disabled plane");

  a_vsync_pol: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    1'b1 |=> vsync_o == ($past(general_output_reg[VGS_MISC_VSP]) ^
                         $past(timing_i.vsync_raw ||
                               (feature_ctrl_reg[VGS_FCR_VSC] && timing_i.vdisp_en))))
    else $error("vertical sync polarity wrong");

  a_screen_off: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    sequencer_clocking_ctrl[VGS_CLK_SCR_OFF] |=> blank_o)
    else $error("screen not blanked");

  a_async_halt: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    async_halt [*2] |=> !dot_en_o && !char_en_o && !load_en_o)
    else $error("sequencer running under halt");

  a_status_one: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    io_req_i.rd && hit_status1 && !io_req_i.wr
    |=> io_rdata_o[0] == $past(timing_i.vretrace || timing_i.hretrace)
        && io_rdata_o[3] == $past(timing_i.vretrace))
    else $error("status one retrace bits wrong");

endmodule // vgs_regs

// *** vgs_host_model.sv ***
// vgs_host_model: host processor issuing byte-wide i/o reads and writes
// assumes registered read data one cycle after the read strobe
`timescale 1ns/10ps
module vgs_host_model
  import vgs_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic [7:0]  io_rdata_i,
  input  wire logic        io_rvalid_i,
  output vgs_io_req_t      io_req_o
);
  initial io_req_o = '0;

  // released bus shows inverted values so stale data never looks valid
  task automatic put(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    #1;
    io_req_o = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk_sys_i);
    #1;
    io_req_o = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
  endtask

  task automatic get(input logic [15:0] a, output logic [7:0] d, output logic v);
    @(posedge clk_sys_i);
    #1;
    io_req_o = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(posedge clk_sys_i);
    #1;
    d = io_rdata_i;
    v = io_rvalid_i;
    io_req_o = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'hFF};
  endtask
endmodule // vgs_host_model

// *** tb.sv ***
// tb: self-checking bench for the general and sequencer register bank
// assumes the host model performs every i/o cycle
`timescale 1ns/10ps
module tb;
  import vgs_pkg::*;
  localparam logic [7:0] MSK [4] = '{VGS_MASK_RESET, VGS_MASK_CLOCK, VGS_MASK_PLANE, VGS_MASK_FONT};
  localparam logic [7:0] CFG [6] = '{8'h00, 8'h01, 8'h09, 8'h05, 8'h15, 8'h18};
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i = 1'b0;
  vgs_io_req_t io_req;
  vgs_timing_t tim = '0;
  vgs_pclk_t   pclk;
  logic [7:0]  rdata, rnd = 8'h40, pix = 8'h00, m_misc, s, m_seq [4];
  logic [1:0]  psel = 2'h0;
  logic [3:0]  cpw = 4'h0, plane;
  logic [2:0]  slot;
  logic        rvalid, irq = 0, col = 0, mreq = 0, ereq = 0, m_unl = 0;
  logic        vs, hs, blank, page, grant, unl, exen, run, dot, chr, ld;
  logic [15:0] base, other;
  int          error_cnt = 0, tests_run = 0, cyc = 0, c, l, nd, dots, ec, el;

  always #20 clk_sys_i = ~clk_sys_i;

  vgs_host_model i_vgs_host_model (.clk_sys_i(clk_sys_i), .io_rdata_i(rdata),
    .io_rvalid_i(rvalid), .io_req_o(io_req));
  vgs_regs i_vgs_regs (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .io_req_i(io_req),
    .io_rdata_o(rdata), .io_rvalid_o(rvalid), .timing_i(tim), .retrace_irq_pending_i(irq),
    .monitor_color_detect_i(col), .pixel_outputs_i(pix), .plane_pair_sel_i(psel),
    .cpu_mem_req_i(mreq), .cpu_plane_wr_i(cpw), .ext_wr_req_i(ereq), .vsync_o(vs),
    .hsync_o(hs), .blank_o(blank), .page_select_hi_o(page), .pclk_sel_o(pclk),
    .cpu_mem_grant_o(grant), .plane_wr_o(plane), .font_slot_o(slot),
    .ext_unlocked_o(unl), .ext_wr_en_o(exen), .seq_running_o(run), .dot_en_o(dot),
    .char_en_o(chr), .load_en_o(ld));

  function automatic logic [7:0] nxt(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction

  task automatic check(input string w, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", w, exp, seen);
    end
  endtask

  task automatic rchk(input string w, input logic [15:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       v;
    i_vgs_host_model.get(a, d, v);
    check(w, d, e);
    check(w, {7'h0, v}, 8'h01);
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ceiling well above the roughly 4400 cycles the sequence needs
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      finish_test();
    end
  end

  initial
  begin
    repeat (3) @(posedge clk_sys_i);
    #1 rst_n_i = 1'b1;
    rchk("misc reset", VGS_PORT_MISC_RD, 8'h00);
    rchk("fcr reset", VGS_PORT_FCR_RD, 8'h00);
    rchk("guard reset", VGS_PORT_GUARD, 8'h00);
    mreq = 1'b1;
    tim = '{vsync_raw: 1'b1, hsync_raw: 1'b0, vretrace: 1'b0, hretrace: 1'b0, vdisp_en: 1'b1};
    repeat (6)
    begin
      rnd = nxt(rnd);
      m_misc = rnd & 8'hEF;
      i_vgs_host_model.put(VGS_PORT_MISC_WR, rnd);
      rchk("misc", VGS_PORT_MISC_RD, m_misc);
      check("page", {7'h0, page}, {7'h0, m_misc[5]});
      check("pclk", 8'(pclk), m_misc[3] ? 8'h02 : {7'h0, m_misc[2]});
      check("grant", {7'h0, grant}, {7'h0, m_misc[1]});
      check("vsync", {7'h0, vs}, {7'h0, ~m_misc[7]});
      check("hsync", {7'h0, hs}, {7'h0, m_misc[6]});
    end
    for (int b = 0; b < 2; b++)
    begin
      m_misc = {7'h1, b[0]};
      i_vgs_host_model.put(VGS_PORT_MISC_WR, m_misc);
      base = b ? 16'h03DA : 16'h03BA;
      other = b ? 16'h03BA : 16'h03DA;
      tim = '{vsync_raw: 1'b0, hsync_raw: 1'b0, vretrace: 1'b0, hretrace: 1'b0, vdisp_en: 1'b1};
      i_vgs_host_model.put(other, 8'h08);
      rchk("fcr wrong base", VGS_PORT_FCR_RD, 8'h00);
      i_vgs_host_model.put(base, 8'hFF);
      rchk("fcr", VGS_PORT_FCR_RD, 8'h08);
      check("vsync or", {7'h0, vs}, 8'h01);
      repeat (4)
      begin
        rnd = nxt(rnd);
        {tim.vretrace, tim.hretrace, psel, irq, col} = rnd[5:0];
        pix = nxt(rnd);
        s = {2'h0, pix[{psel, 1'b1}], pix[{psel, 1'b0}], tim.vretrace, 2'h0, tim.vretrace | tim.hretrace};
        rchk("status one", base, s);
        rchk("status zero", VGS_PORT_INPUT_STATUS_ZERO_RD, {irq, 2'h0, col, 4'h0});
      end
      rchk("status wrong base", other, 8'h00);
      i_vgs_host_model.put(base, 8'h00);
      // sync output is registered one edge behind the feature write
      @(posedge clk_sys_i);
      #1;
      check("vsync plain", {7'h0, vs}, 8'h00);
    end
    cpw = 4'hF;
    repeat (6)
    begin
      for (int i = 0; i < 4; i++)
      begin
        rnd = nxt(rnd);
        m_seq[i] = rnd & MSK[i];
        i_vgs_host_model.put(VGS_PORT_SEQ_IDX, {rnd[7:4], i[3:0]});
        i_vgs_host_model.put(VGS_PORT_SEQ_DATA, rnd);
        rchk("seq reg", VGS_PORT_SEQ_DATA, m_seq[i]);
      end
      s = m_seq[3];
      check("font slot", {5'h0, slot}, s[3] ? {5'h0, s[1], s[0], s[4]} : {5'h0, s[3], s[2], s[5]});
      check("planes", {4'h0, plane}, {4'h0, m_seq[2][3:0]});
      check("running", {7'h0, run}, {7'h0, &m_seq[0][1:0]});
      check("blank", {7'h0, blank}, {7'h0, m_seq[1][5] | tim.vretrace | tim.hretrace});
    end
    i_vgs_host_model.put(VGS_PORT_SEQ_IDX, 8'h05);
    rchk("seq unmapped", VGS_PORT_SEQ_DATA, 8'h00);
    foreach (CFG[k])
    begin
      i_vgs_host_model.put(VGS_PORT_SEQ_IDX, 8'h00);
      i_vgs_host_model.put(VGS_PORT_SEQ_DATA, 8'h03);
      i_vgs_host_model.put(VGS_PORT_SEQ_IDX, 8'h01);
      i_vgs_host_model.put(VGS_PORT_SEQ_DATA, CFG[k]);
      repeat (80) @(posedge clk_sys_i);
      dots = CFG[k][0] ? 8 : 9;
      ec = 576 / (dots * (CFG[k][3] ? 2 : 1));
      el = ec / (CFG[k][4] ? 4 : CFG[k][2] ? 2 : 1);
      c = 0;
      l = 0;
      nd = 0;
      repeat (576)
      begin
        @(posedge clk_sys_i);
        #1;
        c += chr;
        l += ld;
        nd += dot;
      end
      check("char clocks", 8'(c), 8'(ec));
      check("loads", 8'(l), 8'(el));
      check("dot clocks", 8'(nd >> 2), 8'(CFG[k][3] ? 72 : 144));
      check("dot phase", 8'(nd % 4), 8'h00);
    end
    for (int h = 1; h < 3; h++)
    begin
      i_vgs_host_model.put(VGS_PORT_SEQ_IDX, 8'h00);
      i_vgs_host_model.put(VGS_PORT_SEQ_DATA, 8'(h));
      repeat (40) @(posedge clk_sys_i);
      c = 0;
      repeat (40)
      begin
        @(posedge clk_sys_i);
        #1;
        c += chr;
      end
      check("halted", 8'(c), 8'h00);
    end
    ereq = 1'b1;
    foreach (CFG[k])
    begin
      s = (k == 5) ? 8'h5F : (k == 2) ? 8'hA0 : (k == 3) ? 8'hE0 : (k == 1) ? 8'h20 : 8'h40;
      if (s[7:5] == VGS_GUARD_OPEN)
        m_unl = 1'b1;
      else if (s[7:5] == VGS_GUARD_SHUT)
        m_unl = 1'b0;
      if (k == 5)
        i_vgs_host_model.put(VGS_PORT_SEQ_IDX, 8'h1F);
      i_vgs_host_model.put(k == 5 ? VGS_PORT_SEQ_DATA : VGS_PORT_GUARD, s);
      repeat (3) @(posedge clk_sys_i);
      #1;
      check("unlocked", {7'h0, unl}, {7'h0, m_unl});
      check("ext write", {7'h0, exen}, {7'h0, m_unl});
    end
    rchk("guard", VGS_PORT_GUARD, 8'h40);
    finish_test();
  end
endmodule // tb
